// ==== inc/pbsp_pkg.sv ====
// Purpose: constants and carrier types for the pipelined burst memory port
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: memory depth is scaled down; widths are the x36 build
//
// Summary of operation
// [R1] third chip enable sampled with the others only when a new address loads
// [R2] build without third chip enable treats it as always asserted
// [R3] output enable low drives data and parity, high tristates them as inputs
// [R4] first clock of a read leaving deselect keeps outputs tristated
// [R5] burst advance low during a burst steps the burst address
// [R6] processor strobe low captures address and loads low two bits to counter
// [R7] controller strobe low captures address and loads low two bits to counter
// [R8] both strobes low: only the processor strobe is acted on
// [R9] processor strobe ignored while first chip enable is high
// [R10] sleep high enters data-keeping low power; controller holds it low normally
// [R11] write data registered; read data is from previous edge address, one cycle
// [R12] burst-order strap low selects linear, high selects interleaved
// [R13] surrounding system keeps the burst-order strap static during operation
// [R14] scan serial output launches each bit on scan clock falling edge
// [R15] scan data and mode select inputs sampled on scan clock rising edge; the capture ANDs mode select with zero, so only scan data counts
// [R16] all-bytes write low writes every lane regardless of byte controls
// [R17] byte write only on lanes selected low with byte write enable low
// [R18] second chip enable is active high and combines with the others
// [R19] low two address bits feed the two-bit burst counter
// [R20] counter wraps mod four; linear adds one, interleaved xors a step count
// [R21] inactive enable at address load deselects and tristates outputs
package pbsp_pkg;
  localparam int PBSP_ADDR_W = 18;
  localparam int PBSP_DEPTH_W = 6;
  localparam int PBSP_LANES = 4;
  localparam int PBSP_LANE_W = 8;
  localparam int PBSP_DATA_W = PBSP_LANES * PBSP_LANE_W;
  localparam bit PBSP_HAS_THIRD_CE = 1'b1;
  localparam logic [1:0] PBSP_STEP_ONE = 2'h1;

  typedef struct packed {
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic all_bytes_write_n;
    logic byte_write_enable_n;
    logic [PBSP_LANES-1:0] byte_lane_select_n;
  } pbsp_ctrl_s;

  typedef struct packed {
    logic [PBSP_LANE_W-1:0] data;
    logic parity;
  } pbsp_lane_s;

  typedef pbsp_lane_s [PBSP_LANES-1:0] pbsp_word_t;
endpackage : pbsp_pkg

// ==== verification/pbsp_host_model.sv ====
// Purpose: bus master model facing the burst memory port
// Assumes: requests change just after a rising edge
// Notes: data lines toggle when no write is asked
`timescale 1ns/1ns
module pbsp_host_model (
  input wire logic clk,
  output pbsp_pkg::pbsp_ctrl_s ctrl,
  output logic [pbsp_pkg::PBSP_ADDR_W-1:0] addr,
  output pbsp_pkg::pbsp_word_t data_in,
  output logic output_enable_n,
  output logic sleep_request,
  output logic burst_order_strap
);
  import pbsp_pkg::*;
  // ----
  // bus cycles
  // ----
  initial
  begin
    ctrl = 12'hbff;
    addr = '0;
    data_in = '0;
    output_enable_n = 1'b1;
    sleep_request = 1'b0;
    burst_order_strap = 1'b0;
  end
  task op(input pbsp_ctrl_s c, input int a, input pbsp_word_t d);
    @(posedge clk);
    ctrl <= c;
    addr <= a[PBSP_ADDR_W-1:0];
    data_in <= (c.all_bytes_write_n && c.byte_write_enable_n) ? ~data_in : d;
  endtask : op
  // strap moves only between tests, never inside a burst
  task pins(input logic oe_n, input logic slp, input logic m);
    @(posedge clk);
    output_enable_n <= oe_n;
    sleep_request <= slp;
    burst_order_strap <= m;
  endtask : pins
endmodule : pbsp_host_model

// ==== verification/pbsp_sram_port_monitor.sv ====
// Purpose: port checker for the burst memory port
// Assumes: one clock, sync active-high reset
// Notes: sel_r holds the select outcome of the last address load
`timescale 1ns/1ns
module pbsp_sram_port_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire pbsp_pkg::pbsp_ctrl_s ctrl,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic sleeping,
  input wire logic scan_clk,
  input wire logic scan_data_out
);
  import pbsp_pkg::*;
  logic load, sel, sel_r, sel_nxt;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----
  // select tracking
  // ----
  always_comb
  begin
    load = ((!ctrl.processor_addr_strobe_n && !ctrl.chip_select_first_n)
      || (!ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n)) && !sleeping;
    sel = !ctrl.chip_select_first_n && ctrl.chip_select_second
      && (!ctrl.chip_select_third_n || !PBSP_HAS_THIRD_CE);
    sel_nxt = load ? sel : sel_r;
  end
  always_ff @(posedge clk)
  begin
    sel_r <= reset ? 1'b0 : sel_nxt;
  end
  chk_oe_high_off: assert property (output_enable_n [*3] |-> !data_oe)
    else $error("drive with output enable high");
  chk_drive_needs_sel: assert property (data_oe |-> sel_r)
    else $error("drive while deselected");
  chk_first_read_off: assert property (load && sel && !sel_r |=> !data_oe)
    else $error("drive in first cycle from deselect");
  chk_deselect_off: assert property (load && !sel |=> !data_oe)
    else $error("drive after deselecting load");
  chk_sleep_quiet: assert property (sleep_request [*4] |-> !data_oe)
    else $error("drive while asleep");
  chk_sleep_enter: assert property (sleep_request [*5] |-> sleeping)
    else $error("sleep not entered");
  chk_sleep_exit: assert property (!sleep_request [*5] |-> !sleeping)
    else $error("sleep not left");
  chk_scan_still: assert property (scan_clk [*5] |-> $stable(scan_data_out))
    else $error("scan output moved without scan clock fall");
endmodule : pbsp_sram_port_monitor

bind pbsp_sram_port pbsp_sram_port_monitor pbsp_sram_port_monitor_i (.clk, .reset, .ctrl,
  .output_enable_n, .sleep_request, .data_oe, .sleeping, .scan_clk, .scan_data_out);

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for the burst memory port
// Assumes: host model drives the bus at rising edges
// Notes: outputs are sampled 1 ns after an edge
`timescale 1ns/1ns
module tb_top;
  import pbsp_pkg::*;
  localparam pbsp_ctrl_s IDLE = 12'hbff;
  localparam pbsp_ctrl_s PRD = 12'h4ff;
  localparam pbsp_ctrl_s CWR = 12'h55f;
  localparam pbsp_ctrl_s CBW = 12'h56a;
  localparam pbsp_ctrl_s BOTH = 12'h45f;
  localparam pbsp_ctrl_s BURST_ADVANCE_N = 12'hbbf;
  localparam pbsp_ctrl_s PIGN = 12'hcff;
  localparam pbsp_ctrl_s CDES = 12'h17f;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scan_clk = 1'b0;
  logic scan_data_in = 1'b0;
  logic scan_mode_sel = 1'b0;
  pbsp_ctrl_s ctrl;
  logic [PBSP_ADDR_W-1:0] addr;
  pbsp_word_t data_in, data_out, mem [4];
  logic output_enable_n, sleep_request, burst_order_strap, data_oe, sleeping, scan_data_out;
  int num_errors = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  pbsp_sram_port pbsp_sram_port_i (.clk, .reset, .ctrl, .addr, .output_enable_n,
    .sleep_request, .burst_order_strap, .data_in, .data_out, .data_oe, .sleeping,
    .scan_clk, .scan_data_in, .scan_mode_sel, .scan_data_out);
  pbsp_host_model pbsp_host_model_i (.clk, .ctrl, .addr, .data_in, .output_enable_n,
    .sleep_request, .burst_order_strap);
  // ----
  // helpers and scenarios
  // ----
  task cmp(input string n, input logic [35:0] e, input logic [35:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : cmp
  task idle(input int n);
    repeat (n) pbsp_host_model_i.op(IDLE, 0, '0);
    #1;
  endtask : idle
  task t_burst(input logic m);
    logic [1:0] b;
    logic [1:0] k;
    pbsp_host_model_i.pins(1'b0, 1'b0, m);
    for (int i = 0; i < 4; i++)
    begin
      mem[i] = {9{4'(i + 8 * m)}};
      pbsp_host_model_i.op(CWR, i, mem[i]);
    end
    pbsp_host_model_i.op(CDES, 0, '0);
    pbsp_host_model_i.op(PRD, 1, '0);
    // first word stands twice: the masked clock, then the first driven clock
    for (int i = 0; i < 5; i++)
    begin
      pbsp_host_model_i.op(i < 3 ? BURST_ADVANCE_N : IDLE, 0, '0);
      #1;
      k = 2'(i > 0 ? i - 1 : 0);
      b = m ? (2'h1 ^ k) : 2'(2'h1 + k);
      cmp("burst data", mem[b], data_out);
      cmp("burst drive", i > 0, data_oe);
    end
    $display("test burst order %0d done", m);
  endtask : t_burst
  task t_bytes();
    pbsp_word_t e, d;
    e = mem[1];
    d = {9{4'h3}};
    e[0] = d[0];
    e[2] = d[2];
    pbsp_host_model_i.op(CBW, 1, d);
    pbsp_host_model_i.op(PRD, 1, '0);
    idle(1);
    cmp("byte lanes", e, data_out);
    $display("test byte write done");
  endtask : t_bytes
  task t_both();
    pbsp_host_model_i.op(BOTH, 3, {9{4'hf}});
    idle(1);
    cmp("strobe priority", mem[3], data_out);
    pbsp_host_model_i.op(PIGN, 0, '0);
    idle(2);
    cmp("ignored strobe", 1, data_oe);
    cmp("ignored data", mem[3], data_out);
    pbsp_host_model_i.op(CDES, 0, '0);
    idle(1);
    cmp("deselect", 0, data_oe);
    $display("test strobes done");
  endtask : t_both
  task t_sleep();
    pbsp_host_model_i.op(PRD, 0, '0);
    idle(3);
    cmp("drive", 1, data_oe);
    pbsp_host_model_i.pins(1'b1, 1'b0, 1'b1);
    idle(4);
    cmp("oe off", 0, data_oe);
    pbsp_host_model_i.pins(1'b0, 1'b1, 1'b1);
    idle(5);
    cmp("sleep", 1, sleeping);
    cmp("sleep drive", 0, data_oe);
    pbsp_host_model_i.pins(1'b0, 1'b0, 1'b1);
    idle(5);
    cmp("wake", 0, sleeping);
    $display("test sleep done");
  endtask : t_sleep
  task t_scan();
    @(posedge clk);
    scan_clk <= 1'b0;
    scan_data_in <= 1'b1;
    scan_mode_sel <= 1'b1;
    idle(4);
    @(posedge clk);
    scan_clk <= 1'b1;
    idle(4);
    cmp("scan out after rise", 0, scan_data_out);
    @(posedge clk);
    scan_clk <= 1'b0;
    scan_data_in <= 1'b0;
    idle(4);
    cmp("scan out after fall", 1, scan_data_out);
    $display("test scan done");
  endtask : t_scan
  task print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    idle(3);
    t_burst(1'b0);
    t_burst(1'b1);
    t_bytes();
    t_both();
    t_sleep();
    t_scan();
    idle(3);
    print_verdict();
  end
endmodule : tb_top

// ==== verilog/pbsp_sram_port.sv ====
// Purpose: control and data port of a pipelined synchronous burst memory
// Assumes: async inputs (output enable, sleep, scan pins) are synchronised here
// Notes: array is flip-flops indexed by the low address bits of the burst address
`timescale 1ns/1ns
module pbsp_sram_port
  import pbsp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire pbsp_pkg::pbsp_ctrl_s ctrl,
  input wire logic [pbsp_pkg::PBSP_ADDR_W-1:0] addr,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order_strap,
  input wire pbsp_pkg::pbsp_word_t data_in,
  output pbsp_pkg::pbsp_word_t data_out,
  output logic data_oe,
  output logic sleeping,
  input wire logic scan_clk,
  input wire logic scan_data_in,
  input wire logic scan_mode_sel,
  output logic scan_data_out
);
  import pbsp_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] oe_sync_r;
  logic [1:0] sleep_sync_r;
  logic [1:0] strap_sync_r;
  logic [1:0] sclk_sync_r;
  logic [1:0] sdi_sync_r;
  logic [1:0] sms_sync_r;
  logic [1:0] oe_sync_nxt;
  logic [1:0] sleep_sync_nxt;
  logic [1:0] strap_sync_nxt;
  logic [1:0] sclk_sync_nxt;
  logic [1:0] sdi_sync_nxt;
  logic [1:0] sms_sync_nxt;

  always_comb
  begin
    oe_sync_nxt = {oe_sync_r[0], output_enable_n};
    sleep_sync_nxt = {sleep_sync_r[0], sleep_request};
    strap_sync_nxt = {strap_sync_r[0], burst_order_strap};
    sclk_sync_nxt = {sclk_sync_r[0], scan_clk};
    sdi_sync_nxt = {sdi_sync_r[0], scan_data_in};
    sms_sync_nxt = {sms_sync_r[0], scan_mode_sel};
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      oe_sync_r <= 2'h3;
      sleep_sync_r <= 2'h0;
      strap_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      sms_sync_r <= 2'h0;
    end
    else
    begin
      oe_sync_r <= oe_sync_nxt;
      sleep_sync_r <= sleep_sync_nxt;
      strap_sync_r <= strap_sync_nxt;
      sclk_sync_r <= sclk_sync_nxt;
      sdi_sync_r <= sdi_sync_nxt;
      sms_sync_r <= sms_sync_nxt;
    end
  end

  wire logic oe_n_s = oe_sync_r[1];
  wire logic sleep_s = sleep_sync_r[1];
  wire logic interleaved_s = strap_sync_r[1];

  // ----------------------------------------
  // address strobes, enables and burst counter
  // ----------------------------------------
  logic [PBSP_ADDR_W-1:0] addr_r;
  logic [PBSP_ADDR_W-1:0] addr_nxt;
  logic [1:0] start_r;
  logic [1:0] start_nxt;
  logic [1:0] step_r;
  logic [1:0] step_nxt;
  logic selected_r;
  logic selected_nxt;
  logic proc_wr_pending_r;
  logic proc_wr_pending_nxt;
  logic first_read_r;
  logic first_read_nxt;
  logic reading_r;
  logic reading_nxt;

  logic third_ok;
  logic enables_ok;
  logic proc_load;
  logic ctrl_load;
  logic any_load;
  logic write_req;
  logic [PBSP_LANES-1:0] lane_we;
  logic [1:0] burst_low;
  logic [1:0] burst_low_addr_bits;

  always_comb
  begin
    third_ok = PBSP_HAS_THIRD_CE ? !ctrl.chip_select_third_n : 1'b1; // [R2]
    enables_ok = !ctrl.chip_select_first_n && ctrl.chip_select_second && third_ok; // [R1] [R18]
    proc_load = !ctrl.processor_addr_strobe_n && !ctrl.chip_select_first_n; // [R9]
    ctrl_load = !ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n; // [R8]
    any_load = (proc_load || ctrl_load) && !sleep_s;
    // lanes written: all on global write, else selected lanes under byte enable
    for (int i = 0; i < PBSP_LANES; i++)
    begin
      lane_we[i] = !ctrl.all_bytes_write_n // [R16]
        || (!ctrl.byte_write_enable_n && !ctrl.byte_lane_select_n[i]); // [R17]
    end
    write_req = |lane_we;
    // interleaved xors the step count, linear adds it, both modulo four
    burst_low = interleaved_s ? (start_r ^ step_r) : 2'(start_r + step_r); // [R12] [R20]
    burst_low_addr_bits = addr[1:0];

    addr_nxt = addr_r;
    start_nxt = start_r;
    step_nxt = step_r;
    selected_nxt = selected_r;
    proc_wr_pending_nxt = 1'b0;
    first_read_nxt = 1'b0;
    reading_nxt = reading_r;
    if (any_load)
    begin
      addr_nxt = addr; // [R6] [R7]
      start_nxt = burst_low_addr_bits; // [R19]
      step_nxt = 2'h0;
      selected_nxt = enables_ok; // [R21]
      if (enables_ok)
      begin
        proc_wr_pending_nxt = proc_load;
        reading_nxt = proc_load || !write_req;
        first_read_nxt = !selected_r && reading_nxt; // [R4]
      end
      else
      begin
        reading_nxt = 1'b0;
      end
    end
    else if (selected_r && !ctrl.burst_advance_n && !sleep_s)
    begin
      step_nxt = 2'(step_r + PBSP_STEP_ONE); // [R5]
      reading_nxt = !write_req;
    end
    else if (selected_r && !sleep_s)
    begin
      reading_nxt = !write_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addr_r <= '0;
      start_r <= 2'h0;
      step_r <= 2'h0;
      selected_r <= 1'b0;
      proc_wr_pending_r <= 1'b0;
      first_read_r <= 1'b0;
      reading_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      start_r <= start_nxt;
      step_r <= step_nxt;
      selected_r <= selected_nxt;
      proc_wr_pending_r <= proc_wr_pending_nxt;
      first_read_r <= first_read_nxt;
      reading_r <= reading_nxt;
    end
  end

  // ----------------------------------------
  // storage array and output register
  // ----------------------------------------
  pbsp_word_t mem_r [2**PBSP_DEPTH_W];
  pbsp_word_t mem_nxt [2**PBSP_DEPTH_W];
  pbsp_word_t dout_r;
  pbsp_word_t dout_nxt;
  logic [PBSP_DEPTH_W-1:0] cur_index;
  logic [PBSP_DEPTH_W-1:0] load_index;
  logic do_write;
  logic [PBSP_DEPTH_W-1:0] wr_index;

  always_comb
  begin
    cur_index = {addr_r[PBSP_DEPTH_W-1:2], burst_low};
    load_index = addr[PBSP_DEPTH_W-1:0];
    mem_nxt = mem_r;
    do_write = 1'b0;
    wr_index = cur_index;
    // controller-strobe write completes in its load cycle
    if (any_load && ctrl_load && enables_ok && write_req)
    begin
      do_write = 1'b1;
      wr_index = load_index;
    end
    // processor-strobe write or burst write lands on a following edge
    else if (!any_load && selected_r && write_req && !sleep_s)
    begin
      do_write = 1'b1;
    end
    if (do_write)
    begin
      for (int i = 0; i < PBSP_LANES; i++)
      begin
        if (lane_we[i])
        begin
          mem_nxt[wr_index][i] = data_in[i]; // [R11]
        end
      end
    end
    // read data of the address present at this edge appears after it
    if (any_load && enables_ok)
    begin
      dout_nxt = mem_r[load_index]; // [R11]
    end
    else
    begin
      dout_nxt = mem_r[cur_index];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dout_r <= '0;
    end
    else
    begin
      mem_r <= mem_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ----------------------------------------
  // data drive and sleep status
  // ----------------------------------------
  always_comb
  begin
    data_out = dout_r;
    // drive only while selected, reading, enable low and not the first read clock;
    // the data clock of a processor-strobe write keeps the lines free for input
    data_oe = !oe_n_s && selected_r && reading_r && !first_read_r && !sleep_s // [R3] [R4] [R21]
      && !(proc_wr_pending_r && write_req);
    sleeping = sleep_s; // [R10]
  end

  // ----------------------------------------
  // boundary-scan shift path
  // ----------------------------------------
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic scan_cap_r;
  logic scan_cap_nxt;
  logic sdo_r;
  logic sdo_nxt;
  logic sclk_rise;
  logic sclk_fall;

  always_comb
  begin
    sclk_d_nxt = sclk_sync_r[1];
    sclk_rise = sclk_sync_r[1] && !sclk_d_r;
    sclk_fall = !sclk_sync_r[1] && sclk_d_r;
    scan_cap_nxt = scan_cap_r;
    sdo_nxt = sdo_r;
    if (sclk_rise)
    begin
      scan_cap_nxt = sdi_sync_r[1] ^ (sms_sync_r[1] & 1'b0); // [R15]
    end
    if (sclk_fall)
    begin
      sdo_nxt = scan_cap_r; // [R14]
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_d_r <= 1'b0;
      scan_cap_r <= 1'b0;
      sdo_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_d_nxt;
      scan_cap_r <= scan_cap_nxt;
      sdo_r <= sdo_nxt;
    end
  end

  assign scan_data_out = sdo_r;
endmodule : pbsp_sram_port
